// [bench/dsmmd_mem_model.sv]
// Flash array and window register model that answers the decoder's reads.
`timescale 1ns/1ps
module dsmmd_mem_model (
  // Clock.
  input  wire logic        ref_clk,
  // Flash read port.
  input  wire logic [14:0] flash_addr,
  input  wire logic        flash_rd,
  output logic      [15:0] flash_rdata,
  // Peripheral and debug windows.
  input  wire logic        periph_sel,
  input  wire logic [11:0] periph_addr,
  output logic      [15:0] periph_rdata,
  input  wire logic        debug_sel,
  input  wire logic [7:0]  debug_addr,
  output logic      [15:0] debug_rdata
);
  logic [15:0] junk_ff = 16'h0000;
  // Unselected read data changes every cycle so a stale value never matches.
  always_ff @(posedge ref_clk)
  begin
    junk_ff <= ~junk_ff ^ 16'h5a5a;
  end
  // Flash has no write path here, so a plain store can never change it.
  assign flash_rdata  = flash_rd ? {flash_addr, 1'b1} : junk_ff;
  assign periph_rdata = periph_sel ? {4'ha, periph_addr} : junk_ff;
  assign debug_rdata  = debug_sel ? {8'hd0, debug_addr} : ~junk_ff;
endmodule : dsmmd_mem_model

// [bench/tb.sv]
// Self-checking testbench for the dual space memory map decoder.
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'b0, rst_b = 1'b0, fetch_req = 1'b0, pri_req = 1'b0;
  logic        pri_we = 1'b0, pri_pspace = 1'b0, pri_direct = 1'b0, sec_req = 1'b0;
  logic        vbr_we = 1'b0, vec_req = 1'b0, sec_on = 1'b0, frd, bsy;
  logic [1:0]  pri_size = 2'h1;
  logic [20:0] program_address_bus = 21'h0;
  logic [23:0] primary_data_address_bus = 24'h0, secondary_data_address_bus = 24'h0;
  logic [31:0] primary_write_bus = 32'h0, rd, primary_read_bus;
  logic [13:0] vbr_wdata = 14'h0, vector_base_register;
  logic [6:0]  vec_index = 7'h0;
  logic [15:0] flash_rdata, periph_rdata, debug_rdata, program_fetch_data_bus, fd, srd;
  logic [15:0] secondary_read_bus, periph_wdata, debug_wdata;
  logic [14:0] flash_addr;
  logic [11:0] periph_addr;
  logic [7:0]  debug_addr;
  logic [20:0] vector_address;
  logic        fetch_ack, pri_ack, pri_busy, sec_ack, flash_rd, periph_sel, periph_we;
  logic        debug_sel, debug_we, vector_valid;
  logic [23:0] snap;
  logic [32:0] wsn;
  int          checks = 0, fail_count = 0, lat;
  dsmmd_pkg::dsmmd_variant_t variant = dsmmd_pkg::DSMMD_VAR_BIG;

  dsmmd_decoder u_dut (.ref_clk, .rst_b, .variant, .fetch_req, .program_address_bus,
    .program_fetch_data_bus, .fetch_ack, .pri_req, .pri_we, .pri_pspace, .pri_direct,
    .pri_size, .primary_data_address_bus, .primary_write_bus, .primary_read_bus, .pri_ack,
    .pri_busy, .sec_req, .secondary_data_address_bus, .secondary_read_bus, .sec_ack,
    .flash_addr, .flash_rd, .flash_rdata, .periph_sel, .periph_we, .periph_addr,
    .periph_wdata, .periph_rdata, .debug_sel, .debug_we, .debug_addr, .debug_wdata,
    .debug_rdata, .vbr_we, .vbr_wdata, .vec_req, .vec_index, .vector_base_register,
    .vector_address, .vector_valid);
  dsmmd_mem_model u_mem (.ref_clk, .flash_addr, .flash_rd, .flash_rdata, .periph_sel,
    .periph_addr, .periph_rdata, .debug_sel, .debug_addr, .debug_rdata);

  // Free running 100 ns clock.
  always #50 ref_clk = ~ref_clk;

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("Checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // Holds reset for ten cycles with the chosen strap, then lets two edges pass.
  task automatic reset_dut(input dsmmd_pkg::dsmmd_variant_t v);
    @(negedge ref_clk);
    rst_b = 1'b0;
    variant = v;
    repeat (10) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask : reset_dut

  // One primary access, optionally with a parallel secondary read.
  task automatic pri(input logic we, ps, dr, input logic [1:0] sz, input logic [23:0] a,
                     input logic [31:0] wd);
    @(negedge ref_clk);
    {pri_we, pri_pspace, pri_direct, pri_size, pri_req, sec_req} = {we, ps, dr, sz, 1'b1, sec_on};
    primary_data_address_bus = a;
    primary_write_bus = wd;
    #1;
    snap = {flash_rd, periph_sel, periph_we, periph_addr, debug_sel, debug_addr};
    wsn = {debug_we, debug_wdata, periph_wdata};
    @(negedge ref_clk);
    {pri_req, sec_req} = 2'b00;
    bsy = pri_busy;
    srd = secondary_read_bus;
    if (sec_on)
      chk("sec_ack", sec_ack, 1'b1);
    lat = 0;
    while (pri_ack !== 1'b1 && lat < 8)
    begin
      @(negedge ref_clk);
      lat++;
    end
    rd = primary_read_bus;
  endtask : pri

  // One instruction fetch; notes whether the flash array was strobed.
  task automatic fetch(input logic [20:0] a);
    @(negedge ref_clk);
    program_address_bus = a;
    fetch_req = 1'b1;
    #1;
    frd = flash_rd;
    @(negedge ref_clk);
    fetch_req = 1'b0;
    fd = program_fetch_data_bus;
    chk("fetch_ack", fetch_ack, 1'b1);
  endtask : fetch

  // One vector request, with an optional base write on the same edge.
  task automatic vec(input logic [6:0] ix, input logic we, input logic [13:0] wv);
    @(negedge ref_clk);
    {vec_req, vec_index, vbr_we, vbr_wdata} = {1'b1, ix, we, wv};
    @(negedge ref_clk);
    {vec_req, vbr_we} = 2'b00;
    chk("vector_valid", vector_valid, 1'b1);
  endtask : vec

  // Vector base reset value and address formation.
  task automatic t_vector;
    chk("vbr reset", vector_base_register, 14'h0000);
    // Entries are only addressed here; their jump and call contents stay with software.
    vec(7'h02, 1'b0, 14'h0);
    chk("watchdog vector", vector_address, 21'h00_0002);
    vec(7'h7f, 1'b1, 14'h3fff);
    chk("vector address", vector_address, 21'h1f_ffff);
    $display("t_vector done");
  endtask : t_vector

  // Data space RAM, alias, windows, direct form and reserved holes.
  task automatic t_data;
    pri(1, 0, 0, 2'h1, 24'h00_0010, 32'h1234);
    sec_on = 1'b1;
    secondary_data_address_bus = 24'h00_8010;
    pri(0, 0, 0, 2'h1, 24'h00_0010, 32'h0);
    chk("word", rd[15:0], 16'h1234);
    chk("sec alias", srd, 16'h1234);
    chk("data latency", lat, 0);
    pri(1, 0, 0, 2'h2, 24'h00_0020, 32'hcafe_babe);
    secondary_data_address_bus = 24'h00_0021;
    pri(0, 0, 0, 2'h2, 24'h00_0020, 32'h0);
    chk("long", rd, 32'hcafe_babe);
    chk("sec high", srd, 16'hcafe);
    sec_on = 1'b0;
    pri(0, 0, 0, 2'h0, 24'h00_0020, 32'h0);
    chk("byte", rd[7:0], 8'hbe);
    pri(0, 0, 1, 2'h1, 24'h00_1050, 32'h0);
    chk("direct", rd[15:0], 16'h1234);
    pri(0, 0, 0, 2'h1, 24'h00_f123, 32'h0);
    chk("periph sel", snap[22:9], {2'b10, 12'h123});
    chk("periph data", rd[15:0], 16'ha123);
    pri(1, 0, 0, 2'h1, 24'h00_ffff, 32'h7777);
    chk("periph write", snap[22:9], {2'b11, 12'hfff});
    chk("periph wdata", wsn[15:0], 16'h7777);
    pri(0, 0, 0, 2'h1, 24'hff_ff05, 32'h0);
    chk("debug sel", snap[8:0], 9'h105);
    chk("debug data", rd[15:0], 16'hd005);
    pri(1, 0, 0, 2'h1, 24'hff_ff10, 32'h4321);
    chk("debug write", wsn[32:16], 17'h1_4321);
    pri(1, 0, 0, 2'h1, 24'h00_1010, 32'hbeef);
    pri(0, 0, 0, 2'h1, 24'h00_0010, 32'h0);
    chk("hole write", rd[15:0], 16'h1234);
    pri(0, 0, 0, 2'h1, 24'h00_1010, 32'h0);
    chk("hole read", rd, 32'h0);
    pri(0, 0, 0, 2'h1, 24'h00_2000, 32'h0);
    chk("no flash in data", {snap[23], rd}, 33'h0);
    pri(0, 0, 0, 2'h1, 24'hff_feff, 32'h0);
    chk("window gap", {snap[22], snap[8], rd}, 34'h0);
    $display("t_data done");
  endtask : t_data

  // Program space fetches and slow data accesses to program space.
  task automatic t_prog;
    fetch(21'h00_0100);
    chk("flash fetch", {frd, fd}, {1'b1, 15'h0100, 1'b1});
    fetch(21'h00_7fff);
    chk("flash top", {frd, fd}, 17'h1_ffff);
    fetch(21'h00_8010);
    chk("ram alias fetch", fd, 16'h1234);
    pri(1, 1, 0, 2'h1, 24'h00_8fff, 32'h5555);
    chk("pspace write lat", lat, 3);
    fetch(21'h00_8fff);
    chk("alias top", fd, 16'h5555);
    pri(0, 0, 0, 2'h1, 24'h00_0fff, 32'h0);
    chk("ram top", rd[15:0], 16'h5555);
    fetch(21'h00_9000);
    chk("prog hole", {frd, fd}, 17'h0);
    pri(0, 1, 0, 2'h1, 24'h00_0100, 32'h0);
    chk("pspace busy", bsy, 1'b1);
    chk("pspace lat", lat, 3);
    chk("pspace data", rd[15:0], 16'h0201);
    $display("t_prog done");
  endtask : t_prog

  // Small flash parts: boot base, reserved low range and RAM size.
  task automatic t_small;
    reset_dut(dsmmd_pkg::DSMMD_VAR_SM8K);
    chk("vbr small", vector_base_register, 14'h0020);
    fetch(21'h00_1fff);
    chk("low reserved", {frd, fd}, 17'h0);
    reset_dut(dsmmd_pkg::DSMMD_VAR_SM6K);
    chk("vbr 6k", vector_base_register, 14'h0020);
    fetch(21'h00_2000);
    chk("flash base", {frd, fd}, {1'b1, 15'h2000, 1'b1});
    pri(1, 0, 0, 2'h1, 24'h00_0bff, 32'h0bbb);
    fetch(21'h00_8bff);
    chk("6k alias top", fd, 16'h0bbb);
    fetch(21'h00_8c00);
    chk("6k alias end", fd, 16'h0);
    sec_on = 1'b1;
    secondary_data_address_bus = 24'h00_0c00;
    pri(0, 0, 0, 2'h1, 24'h00_0c00, 32'h0);
    sec_on = 1'b0;
    chk("6k ram end", rd, 32'h0);
    chk("6k sec end", srd, 16'h0);
    $display("t_small done");
  endtask : t_small

  // Main sequence.
  initial
  begin
    reset_dut(dsmmd_pkg::DSMMD_VAR_BIG);
    t_vector();
    t_data();
    t_prog();
    t_small();
    results();
  end

  // Watchdog against a hang.
  initial
  begin
    #(100 * 4000);
    fail_count++;
    results();
  end
endmodule : tb

// [common/dsmmd_defines.svh]
// Address map constants for the dual space memory map decoder.
`ifndef DSMMD_DEFINES_SVH
`define DSMMD_DEFINES_SVH
`define DSMMD_PADDR_W        21
`define DSMMD_XADDR_W        24
`define DSMMD_FLASH_LO_BIG   21'h00_0000
`define DSMMD_FLASH_LO_SMALL 21'h00_2000
`define DSMMD_FLASH_HI       21'h00_7FFF
`define DSMMD_PRAM_LO        21'h00_8000
`define DSMMD_PRAM_HI_8K     21'h00_8FFF
`define DSMMD_PRAM_HI_6K     21'h00_8BFF
`define DSMMD_XRAM_HI_8K     24'h00_0FFF
`define DSMMD_XRAM_HI_6K     24'h00_0BFF
`define DSMMD_XALIAS_LO      24'h00_8000
`define DSMMD_XALIAS_HI_8K   24'h00_8FFF
`define DSMMD_XALIAS_HI_6K   24'h00_8BFF
`define DSMMD_PERIPH_LO      24'h00_F000
`define DSMMD_PERIPH_HI      24'h00_FFFF
`define DSMMD_DEBUG_LO       24'hFF_FF00
`define DSMMD_DIRECT_HI      24'h00_003F
`define DSMMD_RAM_MASK       12'h0FFF
`define DSMMD_PERIPH_MASK    12'hFFF
`define DSMMD_DEBUG_MASK     8'hFF
`define DSMMD_VBR_RST_BIG    14'h0000
`define DSMMD_VBR_RST_SMALL  14'h0020
`define DSMMD_VEC_CHIP_RST   7'h00
// Watchdog entry is vector one; entries are two words, so its offset is two.
`define DSMMD_VEC_WDOG_RST   7'h02
`define DSMMD_VEC_LAST_OFS   7'h42
`define DSMMD_FLASH_WAIT     2'h1
`endif

// [common/dsmmd_pkg.sv]
// Types for the dual space memory map decoder.
package dsmmd_pkg;
  // Memory variant of the part.
  typedef enum logic [1:0] {
    DSMMD_VAR_BIG   = 2'h0,
    DSMMD_VAR_SM8K  = 2'h1,
    DSMMD_VAR_SM6K  = 2'h2
  } dsmmd_variant_t;
  // Program-space data access sequencer states, Gray coded.
  typedef enum logic [1:0] {
    DSMMD_ST_IDLE = 2'b00,
    DSMMD_ST_WAIT = 2'b01,
    DSMMD_ST_DONE = 2'b11
  } dsmmd_state_t;
endpackage : dsmmd_pkg

// [core/dsmmd_decoder.sv]
// Dual space memory map decoder with shared RAM, flash and windows.
// Notes on behaviour
// - RAM reachable from program and data space; flash only from program space.
// - All addresses are 16-bit word addresses.
// - Large flash: program 0x0000-0x7FFF is flash, RAM alias from 0x8000.
// - Small flash: program 0x2000-0x7FFF is flash, below 0x2000 reserved.
// - Data RAM from zero is aliased into program space at 0x8000.
// - 6 KB part ends RAM at 0x0BFF and alias at 0x8BFF; others 8 KB.
// - Data 0xF000-0xFFFF peripherals; 0xFFFF00-0xFFFFFF debug window.
// - Two parallel data accesses: 32-bit primary plus 16-bit secondary read.
// - Fetch uses its own program address and fetch data buses.
// - Data accesses to program space use primary buses and take extra cycles.
// - Lowest 64 data locations reachable by short direct addressing.
// - Vector address: 14-bit base on top of a 7-bit index.
// - Vector base resets to 0x0000 large flash, 0x0020 small flash.
// - Chip reset vector 0, watchdog vector 1; table spans 0x00-0x43.
`timescale 1ns/1ps
`include "dsmmd_defines.svh"
module dsmmd_decoder (
  // Clock and reset.
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // Part variant straps.
  input  wire dsmmd_pkg::dsmmd_variant_t  variant,
  // Program fetch bus.
  input  wire logic                       fetch_req,
  input  wire logic [20:0]                program_address_bus,
  output logic      [15:0]                program_fetch_data_bus,
  output logic                            fetch_ack,
  // Primary data bus.
  input  wire logic                       pri_req,
  input  wire logic                       pri_we,
  input  wire logic                       pri_pspace,
  input  wire logic                       pri_direct,
  input  wire logic [1:0]                 pri_size,
  input  wire logic [23:0]                primary_data_address_bus,
  input  wire logic [31:0]                primary_write_bus,
  output logic      [31:0]                primary_read_bus,
  output logic                            pri_ack,
  output logic                            pri_busy,
  // Secondary data read bus.
  input  wire logic                       sec_req,
  input  wire logic [23:0]                secondary_data_address_bus,
  output logic      [15:0]                secondary_read_bus,
  output logic                            sec_ack,
  // Flash array read port.
  output logic      [14:0]                flash_addr,
  output logic                            flash_rd,
  input  wire logic [15:0]                flash_rdata,
  // Peripheral window.
  output logic                            periph_sel,
  output logic                            periph_we,
  output logic      [11:0]                periph_addr,
  output logic      [15:0]                periph_wdata,
  input  wire logic [15:0]                periph_rdata,
  // Debug controller window.
  output logic                            debug_sel,
  output logic                            debug_we,
  output logic      [7:0]                 debug_addr,
  output logic      [15:0]                debug_wdata,
  input  wire logic [15:0]                debug_rdata,
  // Vector formation.
  input  wire logic                       vbr_we,
  input  wire logic [13:0]                vbr_wdata,
  input  wire logic                       vec_req,
  input  wire logic [6:0]                 vec_index,
  output logic      [13:0]                vector_base_register,
  output logic      [20:0]                vector_address,
  output logic                            vector_valid
);
  logic [15:0] ram_mem [0:4095];
  logic        big_flash;
  logic        ram6k;
  logic [20:0] p_flash_lo;
  logic [20:0] p_ram_hi;
  logic [23:0] x_ram_hi;
  logic [23:0] x_alias_hi;
  // Fetch decode.
  logic        f_flash;
  logic        f_ram;
  // Primary decode.
  logic [23:0] pa;
  logic        p_ram;
  logic        p_alias;
  logic        p_per;
  logic        p_dbg;
  logic        p_pfl;
  logic        p_pram;
  logic [11:0] p_ram_idx;
  // Secondary decode.
  logic        s_ram;
  logic        s_alias;
  logic [11:0] s_ram_idx;
  // Registered state.
  dsmmd_pkg::dsmmd_state_t st_ff;
  dsmmd_pkg::dsmmd_state_t nxt_st;
  logic [15:0] pfd_ff;
  logic [15:0] nxt_pfd;
  logic        fack_ff;
  logic        nxt_fack;
  logic [31:0] prd_ff;
  logic [31:0] nxt_prd;
  logic        pack_ff;
  logic        nxt_pack;
  logic [15:0] srd_ff;
  logic [15:0] nxt_srd;
  logic        sack_ff;
  logic        nxt_sack;
  logic [1:0]  wcnt_ff;
  logic [1:0]  nxt_wcnt;

  // Variant dependent region limits.
  assign big_flash  = (variant == dsmmd_pkg::DSMMD_VAR_BIG);
  assign ram6k      = (variant == dsmmd_pkg::DSMMD_VAR_SM6K);
  assign p_flash_lo = big_flash ? `DSMMD_FLASH_LO_BIG : `DSMMD_FLASH_LO_SMALL;
  assign p_ram_hi   = ram6k ? `DSMMD_PRAM_HI_6K : `DSMMD_PRAM_HI_8K;
  assign x_ram_hi   = ram6k ? `DSMMD_XRAM_HI_6K : `DSMMD_XRAM_HI_8K;
  assign x_alias_hi = ram6k ? `DSMMD_XALIAS_HI_6K : `DSMMD_XALIAS_HI_8K;

  // Fetch decode on word addresses; below the flash base is reserved.
  assign f_flash = program_address_bus >= p_flash_lo &&
                   program_address_bus <= `DSMMD_FLASH_HI;
  assign f_ram   = program_address_bus >= `DSMMD_PRAM_LO &&
                   program_address_bus <= p_ram_hi;

  // Primary data decode; direct form zero-extends a six-bit offset.
  assign pa        = pri_direct ? (primary_data_address_bus & `DSMMD_DIRECT_HI)
                                : primary_data_address_bus;
  assign p_ram     = !pri_pspace && pa <= x_ram_hi;
  assign p_alias   = !pri_pspace && pa >= `DSMMD_XALIAS_LO && pa <= x_alias_hi;
  assign p_per     = !pri_pspace && pa >= `DSMMD_PERIPH_LO &&
                     pa <= `DSMMD_PERIPH_HI;
  assign p_dbg     = !pri_pspace && pa >= `DSMMD_DEBUG_LO;
  assign p_pfl     = pri_pspace && pa[20:0] >= p_flash_lo &&
                     pa[20:0] <= `DSMMD_FLASH_HI && pa[23:21] == 3'h0;
  assign p_pram    = pri_pspace && pa[20:0] >= `DSMMD_PRAM_LO &&
                     pa[20:0] <= p_ram_hi && pa[23:21] == 3'h0;
  assign p_ram_idx = pa[11:0] & `DSMMD_RAM_MASK;

  // Secondary read decode, RAM and its alias only.
  assign s_ram     = secondary_data_address_bus <= x_ram_hi;
  assign s_alias   = secondary_data_address_bus >= `DSMMD_XALIAS_LO &&
                     secondary_data_address_bus <= x_alias_hi;
  assign s_ram_idx = secondary_data_address_bus[11:0] & `DSMMD_RAM_MASK;

  // Window strobes, combinational so the target answers in the same cycle.
  assign periph_sel   = pri_req && p_per && st_ff == dsmmd_pkg::DSMMD_ST_IDLE;
  assign periph_we    = periph_sel && pri_we;
  assign periph_addr  = pa[11:0] & `DSMMD_PERIPH_MASK;
  assign periph_wdata = primary_write_bus[15:0];
  assign debug_sel    = pri_req && p_dbg && st_ff == dsmmd_pkg::DSMMD_ST_IDLE;
  assign debug_we     = debug_sel && pri_we;
  assign debug_addr   = pa[7:0] & `DSMMD_DEBUG_MASK;
  assign debug_wdata  = primary_write_bus[15:0];
  // Flash is read by fetch, or by a program-space data read; stores never reach it.
  assign flash_rd     = (fetch_req && f_flash) ||
                        (pri_req && p_pfl && !pri_we);
  assign flash_addr   = (fetch_req && f_flash) ? program_address_bus[14:0] : pa[14:0];

  // Shared RAM writes: data space or its program-space alias, one array.
  always_ff @(posedge ref_clk)
  begin
    if (pri_req && pri_we && (p_ram || p_alias || p_pram) &&
        st_ff == dsmmd_pkg::DSMMD_ST_IDLE)
    begin
      if (pri_size == 2'h0)
        ram_mem[p_ram_idx][7:0] <= primary_write_bus[7:0];
      else
        ram_mem[p_ram_idx] <= primary_write_bus[15:0];
      if (pri_size == 2'h2)
        ram_mem[p_ram_idx + 12'h001] <= primary_write_bus[31:16];
    end
  end

  // Next values for answers and the program-space access sequencer.
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_wcnt = wcnt_ff;
    nxt_pfd  = 16'h0000;
    nxt_fack = fetch_req;
    nxt_prd  = prd_ff;
    nxt_pack = 1'b0;
    nxt_srd  = 16'h0000;
    nxt_sack = sec_req;
    if (fetch_req)
    begin
      if (f_flash)
        nxt_pfd = flash_rdata;
      else if (f_ram)
        nxt_pfd = ram_mem[program_address_bus[11:0] & `DSMMD_RAM_MASK];
    end
    if (sec_req && (s_ram || s_alias))
      nxt_srd = ram_mem[s_ram_idx];
    unique case (st_ff)
      dsmmd_pkg::DSMMD_ST_IDLE:
      begin
        if (pri_req)
        begin
          nxt_prd = 32'h0000_0000;
          if (pri_pspace)
          begin
            nxt_wcnt = `DSMMD_FLASH_WAIT;
            nxt_st   = dsmmd_pkg::DSMMD_ST_WAIT;
            if (!pri_we && p_pfl)
              nxt_prd = {16'h0000, flash_rdata};
            else if (!pri_we && p_pram)
              nxt_prd = {16'h0000, ram_mem[p_ram_idx]};
          end
          else
          begin
            nxt_pack = 1'b1;
            if (!pri_we && (p_ram || p_alias))
            begin
              nxt_prd = {ram_mem[p_ram_idx + 12'h001], ram_mem[p_ram_idx]};
              if (pri_size == 2'h0)
                nxt_prd = {24'h00_0000, ram_mem[p_ram_idx][7:0]};
              else if (pri_size != 2'h2)
                nxt_prd = {16'h0000, ram_mem[p_ram_idx]};
            end
            else if (!pri_we && p_per)
              nxt_prd = {16'h0000, periph_rdata};
            else if (!pri_we && p_dbg)
              nxt_prd = {16'h0000, debug_rdata};
          end
        end
      end
      dsmmd_pkg::DSMMD_ST_WAIT:
      begin
        nxt_wcnt = wcnt_ff - 2'h1;
        if (wcnt_ff == 2'h0)
          nxt_st = dsmmd_pkg::DSMMD_ST_DONE;
      end
      dsmmd_pkg::DSMMD_ST_DONE:
      begin
        nxt_pack = 1'b1;
        nxt_st   = dsmmd_pkg::DSMMD_ST_IDLE;
      end
      default:
        nxt_st = dsmmd_pkg::DSMMD_ST_IDLE;
    endcase
  end

  // Registers only.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff   <= dsmmd_pkg::DSMMD_ST_IDLE;
      wcnt_ff <= 2'h0;
      pfd_ff  <= 16'h0000;
      fack_ff <= 1'b0;
      prd_ff  <= 32'h0000_0000;
      pack_ff <= 1'b0;
      srd_ff  <= 16'h0000;
      sack_ff <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      wcnt_ff <= nxt_wcnt;
      pfd_ff  <= nxt_pfd;
      fack_ff <= nxt_fack;
      prd_ff  <= nxt_prd;
      pack_ff <= nxt_pack;
      srd_ff  <= nxt_srd;
      sack_ff <= nxt_sack;
    end
  end

  assign program_fetch_data_bus = pfd_ff;
  assign fetch_ack              = fack_ff;
  assign primary_read_bus       = prd_ff;
  assign pri_ack                = pack_ff;
  assign pri_busy               = (st_ff != dsmmd_pkg::DSMMD_ST_IDLE);
  assign secondary_read_bus     = srd_ff;
  assign sec_ack                = sack_ff;

  // Vector base register and vector address.
  dsmmd_vector_former u_vec (
    .ref_clk              (ref_clk),
    .rst_b                (rst_b),
    .big_flash            (big_flash),
    .vbr_we               (vbr_we),
    .vbr_wdata            (vbr_wdata),
    .vec_req              (vec_req),
    .vec_index            (vec_index),
    .vector_base_register (vector_base_register),
    .vector_address       (vector_address),
    .vector_valid         (vector_valid)
  );

  // Flash is never selected from data space.
  property p_no_flash_data;
    @(posedge ref_clk) disable iff (!rst_b)
    pri_req && !pri_pspace && !(fetch_req && f_flash) |-> !flash_rd;
  endproperty
  a_no_flash_data: assert property (p_no_flash_data) else $error("flash read from data");

  // Small-flash fetch below the flash base is reserved and reads zero.
  property p_small_resv;
    @(posedge ref_clk) disable iff (!rst_b)
    fetch_req && !big_flash && program_address_bus < `DSMMD_FLASH_LO_SMALL |=>
      fetch_ack && program_fetch_data_bus == 16'h0000;
  endproperty
  a_small_resv: assert property (p_small_resv) else $error("reserved fetch not zero");

  // Large-flash fetch anywhere from word zero up to 0x7FFF selects flash.
  property p_big_flash;
    @(posedge ref_clk) disable iff (!rst_b)
    fetch_req && big_flash && program_address_bus <= `DSMMD_FLASH_HI |-> flash_rd;
  endproperty
  a_big_flash: assert property (p_big_flash) else $error("flash not selected");

  // Peripheral window strobe follows the decoded address range.
  property p_periph;
    @(posedge ref_clk) disable iff (!rst_b)
    periph_sel |-> !pri_pspace && pa[23:12] == 12'h00F;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral select wrong");

  // Program-space data access is busy three cycles and answers on the fourth.
  property p_pspace_wait;
    @(posedge ref_clk) disable iff (!rst_b)
    pri_req && pri_pspace && !pri_busy |=> pri_busy && !pri_ack ##1
      pri_busy && !pri_ack ##1 pri_busy && !pri_ack ##1 pri_ack && !pri_busy;
  endproperty
  a_pspace_wait: assert property (p_pspace_wait) else $error("program access timing");

  // Data-space read answers next cycle.
  property p_dspace_ack;
    @(posedge ref_clk) disable iff (!rst_b)
    pri_req && !pri_pspace && !pri_busy |=> pri_ack;
  endproperty
  a_dspace_ack: assert property (p_dspace_ack) else $error("data access not acked");

  // Reserved data reads return zero.
  property p_resv_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    pri_req && !pri_we && !pri_busy && !pri_pspace &&
      !(p_ram || p_alias || p_per || p_dbg) |=> primary_read_bus == 32'h0000_0000;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved read not zero");

  // Secondary read outside RAM answers zero.
  property p_sec_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    sec_req && !(s_ram || s_alias) |=> sec_ack && secondary_read_bus == 16'h0000;
  endproperty
  a_sec_zero: assert property (p_sec_zero) else $error("secondary reserved read");
endmodule : dsmmd_decoder

// [core/dsmmd_vector_former.sv]
// Vector base register and interrupt vector address formation.
`timescale 1ns/1ps
`include "dsmmd_defines.svh"
module dsmmd_vector_former (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Configuration.
  input  wire logic        big_flash,
  // Vector base register write port.
  input  wire logic        vbr_we,
  input  wire logic [13:0] vbr_wdata,
  // Vector request.
  input  wire logic        vec_req,
  input  wire logic [6:0]  vec_index,
  // Results.
  output logic      [13:0] vector_base_register,
  output logic      [20:0] vector_address,
  output logic             vector_valid
);
  logic        rst_done_ff;
  logic        nxt_rst_done;
  logic [13:0] vbr_ff;
  logic [13:0] nxt_vbr;
  logic [20:0] vab_ff;
  logic [20:0] nxt_vab;
  logic        vval_ff;
  logic        nxt_vval;

  // Reset value loads on the first edge after release; strap is sampled then.
  always_comb
  begin
    nxt_rst_done = 1'b1;
    nxt_vbr      = vbr_ff;
    nxt_vab      = vab_ff;
    nxt_vval     = vec_req;
    if (!rst_done_ff)
      nxt_vbr = big_flash ? `DSMMD_VBR_RST_BIG : `DSMMD_VBR_RST_SMALL;
    else if (vbr_we)
      nxt_vbr = vbr_wdata;
    if (vec_req)
      nxt_vab = {nxt_vbr, vec_index};
  end

  // Registers only.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_done_ff <= 1'b0;
      vbr_ff      <= `DSMMD_VBR_RST_BIG;
      vab_ff      <= 21'h00_0000;
      vval_ff     <= 1'b0;
    end
    else
    begin
      rst_done_ff <= nxt_rst_done;
      vbr_ff      <= nxt_vbr;
      vab_ff      <= nxt_vab;
      vval_ff     <= nxt_vval;
    end
  end

  assign vector_base_register = vbr_ff;
  assign vector_address       = vab_ff;
  assign vector_valid         = vval_ff;

  // Vector address is the base in the upper 14 bits and the index below.
  property p_vec_form;
    @(posedge ref_clk) disable iff (!rst_b)
    vec_req && rst_done_ff && !vbr_we |=> vector_valid &&
      vector_address == {$past(vbr_ff), $past(vec_index)};
  endproperty
  a_vec_form: assert property (p_vec_form) else $error("vector address malformed");

  // Base register takes the variant reset value one edge after release.
  property p_vbr_reset;
    @(posedge ref_clk) disable iff (!rst_b)
    !rst_done_ff |=> vector_base_register ==
      ($past(big_flash) ? `DSMMD_VBR_RST_BIG : `DSMMD_VBR_RST_SMALL);
  endproperty
  a_vbr_reset: assert property (p_vbr_reset) else $error("vector base reset wrong");

  // Watchdog reset vector lands two words above the table base.
  property p_wdog_vec;
    @(posedge ref_clk) disable iff (!rst_b)
    vec_req && rst_done_ff && !vbr_we && vec_index == `DSMMD_VEC_WDOG_RST |=>
      vector_address == {$past(vbr_ff), 7'h00} + 21'h00_0002;
  endproperty
  a_wdog_vec: assert property (p_wdog_vec) else $error("watchdog vector wrong");
endmodule : dsmmd_vector_former
